// >>> rtl/pllrs_top.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module pllrs_top (
  input wire logic pclk, // register and monitor clock
  input wire logic presetn, // async reset, active low
  input wire pllrs_pkg::pllrs_apb_req_t apb_req, // apb request
  output var pllrs_pkg::pllrs_apb_rsp_t apb_rsp, // apb answer
  input wire pllrs_pkg::pllrs_pins_t pins, // reference, select and divider pins
  output var pllrs_pkg::pllrs_ana_t analog // controls to the analog front end
);
  import pllrs_pkg::*;

  typedef struct packed {
    pllrs_apb_rsp_t rsp;
    logic [7:0] pump_ctrl;
    logic [2:0] pump_cur;
    logic [1:0] abl;
    logic cal;
    logic [7:0] ref_cfg;
    logic [1:0] man_sel;
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] prev;
    pllrs_sw_t sw;
    logic [1:0] miss_falls;
    logic [1:0] rev_falls;
    logic [2:0] rev_rises;
    logic use_sec;
    logic hold;
    logic pfd_up;
    logic pfd_dn;
    logic [2:0] abl_cnt;
    pllrs_ana_t ana;
  } pllrs_state_t;

  pllrs_state_t st_r;
  pllrs_state_t st_nxt;

  // word index of a byte address, upper bits must be zero to hit
  function automatic logic [5:0] reg_idx(input logic [11:0] addr);
    reg_idx = (addr[11:8] == 4'h0) ? addr[7:2] : 6'h3F;
  endfunction : reg_idx

  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx == IDX_PUMP_CTRL) || (idx == IDX_ABL) || (idx == IDX_CAL) ||
                 (idx == IDX_REF_CFG) || (idx == IDX_MAN_SEL) || (idx == IDX_STATUS) ||
                 (idx == IDX_PUMP_CUR);
  endfunction : idx_mapped

  // read mux, low bits only, upper bits read zero
  function automatic logic [31:0] read_word(input pllrs_state_t s, input logic [5:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      IDX_PUMP_CTRL: w[7:0] = s.pump_ctrl;
      IDX_ABL: w[1:0] = s.abl;
      IDX_CAL: w[0] = s.cal;
      IDX_REF_CFG: w[7:0] = s.ref_cfg;
      IDX_MAN_SEL: w[1:0] = s.man_sel;
      IDX_PUMP_CUR: w[2:0] = s.pump_cur;
      IDX_STATUS: w[7:0] = {s.pfd_dn, s.pfd_up, s.cal, s.sw, s.hold,
                            (s.miss_falls == MISS_FALLS), s.use_sec};
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction : read_word

  logic [5:0] idx;
  logic wr_go;
  logic loop_pd;
  logic diff_mode;
  logic auto_on;
  logic man_sec;
  logic pri_rise;
  logic pri_edge;
  logic sec_rise;
  logic sec_fall;
  logic ref_div_rise;
  logic fb_rise;
  logic src;
  logic want_sec;
  logic up_raw;
  logic dn_raw;
  logic [2:0] pmode;

  always_comb begin
    st_nxt = st_r;
    idx = reg_idx(apb_req.paddr);
    st_nxt.ana.vco_cal_go = 1'b0;

    // apb slave: one wait state, answer registered in the access phase
    st_nxt.rsp.pready = apb_req.psel & apb_req.penable & ~st_r.rsp.pready;
    st_nxt.rsp.pslverr = 1'b0;
    if (apb_req.psel && apb_req.penable && !st_r.rsp.pready) begin
      st_nxt.rsp.pslverr = ~idx_mapped(idx);
      st_nxt.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : read_word(st_r, idx);
    end
    wr_go = apb_req.psel & apb_req.penable & st_r.rsp.pready & apb_req.pwrite;
    if (wr_go) begin
      case (idx)
        IDX_PUMP_CTRL: st_nxt.pump_ctrl = apb_req.pwdata[7:0];
        IDX_ABL: st_nxt.abl = apb_req.pwdata[1:0];
        IDX_CAL: begin
          st_nxt.cal = apb_req.pwdata[0];
          // start only on a fresh set so rewriting a one does not recalibrate
          st_nxt.ana.vco_cal_go = apb_req.pwdata[0] & ~st_r.cal;
        end
        IDX_REF_CFG: st_nxt.ref_cfg = apb_req.pwdata[7:0];
        IDX_MAN_SEL: st_nxt.man_sel = apb_req.pwdata[1:0];
        IDX_PUMP_CUR: st_nxt.pump_cur = apb_req.pwdata[2:0];
        default: st_nxt.pump_cur = st_r.pump_cur;
      endcase
    end

    // two-flop synchronisers, third stage keeps the previous value for edges
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.prev = st_r.s2;
    pri_rise = st_r.s2[0] & ~st_r.prev[0];
    pri_edge = st_r.s2[0] ^ st_r.prev[0];
    sec_rise = st_r.s2[1] & ~st_r.prev[1];
    sec_fall = ~st_r.s2[1] & st_r.prev[1];
    ref_div_rise = st_r.s2[4] & ~st_r.prev[4];
    fb_rise = st_r.s2[5] & ~st_r.prev[5];

    // reference power; any nonzero power-down code counts as loop off
    loop_pd = (st_r.pump_ctrl[PC_PD_LSB +: 2] != 2'b00);
    diff_mode = st_r.ref_cfg[RC_DIFF_SEL];
    st_nxt.ana.diff_rx_pd = loop_pd | ~diff_mode | ~st_r.ref_cfg[RC_DIFF_EN];
    st_nxt.ana.pri_buf_pd = loop_pd | diff_mode | st_r.ref_cfg[RC_PRI_PD];
    st_nxt.ana.sec_buf_pd = loop_pd | diff_mode | st_r.ref_cfg[RC_SEC_PD];

    // manual choice from register or synchronised pin
    man_sec = st_r.man_sel[MS_USE_PIN] ? st_r.s2[3] : st_r.man_sel[MS_SEC];
    auto_on = st_r.ref_cfg[RC_AUTO] & ~diff_mode;

    // missing-primary monitor, cleared by any primary transition
    if (pri_edge) begin
      st_nxt.miss_falls = 2'h0;
    end else if (sec_fall && st_r.miss_falls != MISS_FALLS) begin
      st_nxt.miss_falls = st_r.miss_falls + 2'h1;
    end

    // switchover state machine
    if (!auto_on) begin
      // manual mode also clears the revert rise and fall counters
      st_nxt.sw = man_sec ? SW_SEC : SW_PRI;
      st_nxt.rev_rises = 3'h0;
      st_nxt.rev_falls = 2'h0;
    end else begin
      case (st_r.sw)
        SW_PRI: begin
          if (st_nxt.miss_falls == MISS_FALLS) begin
            st_nxt.sw = SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (sec_rise) begin
            st_nxt.sw = SW_SEC;
            st_nxt.rev_rises = 3'h0;
            st_nxt.rev_falls = 2'h0;
          end
        end
        SW_SEC: begin
          // rises of primary count, two secondary falls between them restart
          if (pri_rise) begin
            st_nxt.rev_rises = st_r.rev_rises + 3'h1;
            st_nxt.rev_falls = sec_fall ? 2'h1 : 2'h0;
          end else if (sec_fall) begin
            if (st_r.rev_falls + 2'h1 == REVERT_FALLS) begin
              st_nxt.rev_rises = 3'h0;
              st_nxt.rev_falls = 2'h0;
            end else begin
              st_nxt.rev_falls = st_r.rev_falls + 2'h1;
            end
          end
          if (st_nxt.rev_rises == REVERT_RISES) begin
            st_nxt.rev_rises = 3'h0;
            // stay mode and revert-disable both leave the return to software
            if (!st_r.ref_cfg[RC_REVERT_DIS] && !st_r.ref_cfg[RC_STAY_SEC]) begin
              st_nxt.sw = SW_PRI;
            end
          end
        end
        default: st_nxt.sw = SW_PRI;
      endcase
    end
    want_sec = (st_nxt.sw == SW_SEC) & ~diff_mode;

    // deglitch: after a change the output stays low until the new source is
    // low, so its first rising edge is the first edge the detector sees
    st_nxt.use_sec = want_sec;
    src = diff_mode ? st_r.s2[2] : (st_r.use_sec ? st_r.s2[1] : st_r.s2[0]);
    if (want_sec != st_r.use_sec && !st_r.ref_cfg[RC_DEGLITCH_DIS]) begin
      st_nxt.hold = 1'b1;
    end else if (st_r.hold && !src) begin
      st_nxt.hold = 1'b0;
    end
    st_nxt.ana.ref_to_div = st_r.hold ? 1'b0 : src;
    st_nxt.ana.on_secondary = st_r.use_sec;

    // phase-frequency detector with antibacklash overlap
    if (ref_div_rise) begin
      st_nxt.pfd_up = 1'b1;
    end
    if (fb_rise) begin
      st_nxt.pfd_dn = 1'b1;
    end
    if (st_r.pfd_up && st_r.pfd_dn) begin
      // both on: hold the overlap, then reset together to kill the dead zone
      if (st_r.abl_cnt == {1'b0, st_r.abl} + ABL_BASE_CYC) begin
        st_nxt.pfd_up = ref_div_rise;
        st_nxt.pfd_dn = fb_rise;
        st_nxt.abl_cnt = 3'h0;
      end else begin
        st_nxt.abl_cnt = st_r.abl_cnt + 3'h1;
      end
    end else begin
      st_nxt.abl_cnt = 3'h0;
    end

    // pump mode and polarity; a powered-down loop never pumps
    pmode = st_r.pump_ctrl[PC_MODE_LSB +: 3];
    up_raw = st_r.pump_ctrl[PC_POL_BIT] ? st_r.pfd_dn : st_r.pfd_up;
    dn_raw = st_r.pump_ctrl[PC_POL_BIT] ? st_r.pfd_up : st_r.pfd_dn;
    case (pmode)
      PUMP_MODE_NORMAL: begin
        st_nxt.ana.pump_up = up_raw & ~loop_pd;
        st_nxt.ana.pump_dn = dn_raw & ~loop_pd;
      end
      PUMP_MODE_UP: begin
        st_nxt.ana.pump_up = ~loop_pd;
        st_nxt.ana.pump_dn = 1'b0;
      end
      PUMP_MODE_DOWN: begin
        st_nxt.ana.pump_up = 1'b0;
        st_nxt.ana.pump_dn = ~loop_pd;
      end
      default: begin
        // high impedance holds the loop filter voltage for hold-over
        st_nxt.ana.pump_up = 1'b0;
        st_nxt.ana.pump_dn = 1'b0;
      end
    endcase
    st_nxt.ana.pump_current = st_r.pump_cur;
    st_nxt.ana.abl_width = st_r.abl;
  end

  // single state register; all reference inputs start powered down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.pump_ctrl <= PUMP_CTRL_RST;
      st_r.ref_cfg <= REF_CFG_RST;
      st_r.man_sel <= MAN_SEL_RST;
      st_r.ana.diff_rx_pd <= 1'b1;
      st_r.ana.pri_buf_pd <= 1'b1;
      st_r.ana.sec_buf_pd <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_rsp = st_r.rsp;
  assign analog = st_r.ana;

endmodule : pllrs_top

`default_nettype wire

// >>> rtl/pllrs_pkg.sv
package pllrs_pkg;

  // register word indices; byte address is four times the index
  localparam logic [5:0] IDX_PUMP_CTRL = 6'h10;
  localparam logic [5:0] IDX_ABL = 6'h17;
  localparam logic [5:0] IDX_CAL = 6'h18;
  localparam logic [5:0] IDX_REF_CFG = 6'h1C;
  localparam logic [5:0] IDX_MAN_SEL = 6'h1D;
  localparam logic [5:0] IDX_STATUS = 6'h1F;
  localparam logic [5:0] IDX_PUMP_CUR = 6'h20;

  // pump control fields
  localparam int PC_PD_LSB = 0;
  localparam int PC_MODE_LSB = 4;
  localparam int PC_POL_BIT = 7;
  localparam logic [7:0] PUMP_CTRL_RST = 8'h01;

  // pump modes
  localparam logic [2:0] PUMP_MODE_HIZ = 3'h0;
  localparam logic [2:0] PUMP_MODE_UP = 3'h1;
  localparam logic [2:0] PUMP_MODE_DOWN = 3'h2;
  localparam logic [2:0] PUMP_MODE_NORMAL = 3'h3;

  // reference configuration fields
  localparam int RC_DIFF_SEL = 0;
  localparam int RC_PRI_PD = 1;
  localparam int RC_SEC_PD = 2;
  localparam int RC_REVERT_DIS = 3;
  localparam int RC_AUTO = 4;
  localparam int RC_STAY_SEC = 5;
  localparam int RC_DIFF_EN = 6;
  localparam int RC_DEGLITCH_DIS = 7;
  localparam logic [7:0] REF_CFG_RST = 8'h06;

  // manual select fields
  localparam int MS_SEC = 0;
  localparam int MS_USE_PIN = 1;
  localparam logic [1:0] MAN_SEL_RST = 2'h0;

  // monitor thresholds and antibacklash base width in pclk cycles
  localparam logic [1:0] MISS_FALLS = 2'h2;
  localparam logic [1:0] REVERT_FALLS = 2'h2;
  localparam logic [2:0] REVERT_RISES = 3'h4;
  localparam logic [2:0] ABL_BASE_CYC = 3'h1;

  typedef enum logic [1:0] {SW_PRI, SW_WAIT, SW_SEC} pllrs_sw_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pllrs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pllrs_apb_rsp_t;

  // pin order: fb_div, ref_div, ref_sel_pin, ref_input_pin, ref_secondary, ref_primary
  typedef struct packed {
    logic fb_div;
    logic ref_div;
    logic ref_sel_pin;
    logic ref_input_pin;
    logic ref_secondary;
    logic ref_primary;
  } pllrs_pins_t;

  typedef struct packed {
    logic pump_up;
    logic pump_dn;
    logic [2:0] pump_current;
    logic [1:0] abl_width;
    logic vco_cal_go;
    logic diff_rx_pd;
    logic pri_buf_pd;
    logic sec_buf_pd;
    logic ref_to_div;
    logic on_secondary;
  } pllrs_ana_t;

endpackage : pllrs_pkg

// >>> sim/pllrs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pllrs_sva (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire pllrs_pkg::pllrs_apb_req_t apb_req, // bus request
  input wire pllrs_pkg::pllrs_apb_rsp_t apb_rsp, // bus answer
  input wire pllrs_pkg::pllrs_pins_t pins, // pins, driven by the bench
  input wire pllrs_pkg::pllrs_ana_t analog // analog controls
);
  import pllrs_pkg::*;
  logic acc;
  logic wr_go;
  logic [31:0] wd_r;
  // completed write and its data, kept for the copy checks
  assign acc = apb_req.psel && apb_req.penable;
  assign wr_go = acc && apb_req.pwrite && apb_rsp.pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_r <= '0;
    end else if (wr_go) begin
      wd_r <= apb_req.pwdata;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (
    acc && !apb_rsp.pready |=> apb_rsp.pready) else $error("no answer after one wait");
  a_ready_pulse: assert property (
    apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held too long");
  a_unmapped_err: assert property (
    apb_rsp.pready && apb_req.paddr[11:8] != 4'h0 |-> apb_rsp.pslverr) else $error("no error");
  a_err_zero: assert property (
    apb_rsp.pslverr && !apb_req.pwrite |-> apb_rsp.pready && apb_rsp.prdata == 32'h0000_0000)
    else $error("error read not zero");
  a_abl_copy: assert property (
    wr_go && apb_req.paddr == {4'h0, IDX_ABL, 2'h0} |-> ##[1:2] analog.abl_width == wd_r[1:0])
    else $error("abl width not copied");
  a_cur_copy: assert property (
    wr_go && apb_req.paddr == {4'h0, IDX_PUMP_CUR, 2'h0} |-> ##[1:2]
    analog.pump_current == wd_r[2:0]) else $error("pump current not copied");
  a_diff_only: assert property (
    !analog.diff_rx_pd |-> analog.pri_buf_pd && analog.sec_buf_pd) else $error("buffers on");
  a_cal_pulse: assert property (
    $rose(analog.vco_cal_go) |=> !analog.vco_cal_go) else $error("cal pulse too long");
endmodule : pllrs_sva
bind pllrs_top pllrs_sva i_pllrs_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pins(pins), .analog(analog));
`default_nettype wire

// >>> sim/pllrs_ref_src.sv
`timescale 1ns/10ps
`default_nettype none
module pllrs_ref_src (
  input wire logic pclk, // bench clock
  input wire logic pri_run, // primary toggles while high
  input wire logic [1:0] lead, // 0 quiet, 1 reference first, 2 feedback first
  output var logic ref_primary, // primary reference
  output var logic ref_secondary, // secondary reference
  output var logic ref_input_pin, // differential receiver
  output var logic ref_div, // reference divider
  output var logic fb_div // feedback divider
);
  logic [7:0] cnt = 8'h00;
  logic pri_q = 1'b0;
  logic [7:0] c_s;
  logic [7:0] c_lag;
  logic [7:0] c_lead;
  // a stopped primary freezes, which is what a lost source looks like
  always @(posedge pclk) begin
    cnt <= cnt + 8'h01;
    if (pri_run) begin
      pri_q <= cnt[2];
    end
  end
  // sources are dc-coupled and never float, so a switch target always toggles
  assign c_s = cnt + 8'h03;
  assign ref_primary = pri_q;
  assign ref_secondary = c_s[3];
  assign ref_input_pin = cnt[1];
  // dividers offset by four cycles in either direction
  assign c_lag = cnt - 8'h04;
  assign c_lead = cnt + 8'h04;
  assign ref_div = (lead != 2'h0) && cnt[4];
  assign fb_div = (lead == 2'h1) ? c_lag[4] : (lead == 2'h2) ? c_lead[4] : 1'b0;
endmodule : pllrs_ref_src
`default_nettype wire

// >>> sim/pllrs_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pllrs_top_bench;
  import pllrs_pkg::*;
  logic pclk, presetn, sel_pin, pri_run, e;
  logic [1:0] lead;
  logic [31:0] q;
  pllrs_apb_req_t req;
  pllrs_apb_rsp_t rsp;
  pllrs_pins_t pins;
  pllrs_ana_t ana;
  wire logic m_pri, m_sec, m_rin, m_rdiv, m_fdiv;
  int bad_count, n_checks;
  assign pins = {m_fdiv, m_rdiv, sel_pin, m_rin, m_sec, m_pri};
  pllrs_top i_pllrs_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .pins(pins), .analog(ana));
  pllrs_ref_src i_pllrs_ref_src (.pclk(pclk), .pri_run(pri_run), .lead(lead),
    .ref_primary(m_pri), .ref_secondary(m_sec), .ref_input_pin(m_rin), .ref_div(m_rdiv),
    .fb_div(m_fdiv));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [11:0] ba(input logic [5:0] i);
    return {4'h0, i, 2'h0};
  endfunction : ba
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one transfer; waits for pready however long, a dead slave is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    chk({31'h0, e}, {31'h0, (a[11:8] != 4'h0) || a[7:2] == 6'h3F});
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask : rd
  function automatic logic pick(input int k);
    return k == 0 ? ana.on_secondary : k == 1 ? ana.pump_up : k == 2 ? ana.vco_cal_go :
      k == 3 ? ana.ref_to_div : ana.pump_dn;
  endfunction : pick
  // hold: must stay at v for lim cycles; else: must reach v within lim cycles
  // returns just after a rising edge so the caller's next drive lands on it
  task automatic watch(input int k, input logic v, input int lim, input bit hold);
    logic g;
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      g = pick(k);
      n++;
    end while ((hold ? g === v : g !== v) && n < lim);
    chk({31'h0, g}, {31'h0, v});
    @(posedge pclk);
  endtask : watch
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    end_of_test;
  end
  localparam logic [7:0] PC[6] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h31, 8'h31};
  localparam logic [7:0] RC[6] = '{8'h06, 8'h41, 8'h00, 8'h04, 8'h00, 8'h41};
  localparam logic [2:0] PD[6] = '{3'h7, 3'h3, 3'h4, 3'h5, 3'h7, 3'h7};
  localparam logic [7:0] MD[4] = '{8'h10, 8'h20, 8'h00, 8'h70};
  localparam logic [1:0] UD[4] = '{2'h2, 2'h1, 2'h0, 2'h0};
  localparam logic [7:0] AM[3] = '{8'h10, 8'h18, 8'h30};
  initial begin
    presetn = 1'b0;
    req = '0;
    sel_pin = 1'b0;
    pri_run = 1'b1;
    lead = 2'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({ana.diff_rx_pd, ana.pri_buf_pd, ana.sec_buf_pd}, 32'h0000_0007);
    rd(ba(IDX_PUMP_CTRL), 32'h0000_0001);
    rd(ba(IDX_REF_CFG), 32'h0000_0006);
    rd(12'h400, 32'h0000_0000);
    rd(ba(6'h3F), 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ba(IDX_PUMP_CUR), i);
      apb(1'b1, ba(IDX_ABL), i % 4);
      repeat (3) @(negedge pclk);
      chk({ana.pump_current, ana.abl_width}, {i[2:0], i[1:0]});
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ba(IDX_PUMP_CTRL), PC[i]);
      apb(1'b1, ba(IDX_REF_CFG), RC[i]);
      repeat (3) @(negedge pclk);
      chk({ana.diff_rx_pd, ana.pri_buf_pd, ana.sec_buf_pd}, PD[i]);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ba(IDX_PUMP_CTRL), MD[i]);
      repeat (3) @(negedge pclk);
      chk({ana.pump_up, ana.pump_dn}, UD[i]);
    end
    apb(1'b1, ba(IDX_PUMP_CTRL), 8'h30);
    lead <= 2'h1;
    watch(1, 1'b1, 200, 1'b0);
    lead <= 2'h2;
    watch(4, 1'b1, 200, 1'b0);
    lead <= 2'h0;
    $display("test pump done");
    // leave differential mode so the single-ended selection means something
    apb(1'b1, ba(IDX_REF_CFG), 32'h0000_0000);
    apb(1'b1, ba(IDX_MAN_SEL), 32'h0000_0001);
    watch(0, 1'b1, 60, 1'b0);
    watch(3, 1'b1, 60, 1'b0);
    apb(1'b1, ba(IDX_MAN_SEL), 32'h0000_0002);
    watch(0, 1'b0, 60, 1'b0);
    sel_pin <= 1'b1;
    watch(0, 1'b1, 60, 1'b0);
    sel_pin <= 1'b0;
    apb(1'b1, ba(IDX_MAN_SEL), 32'h0000_0000);
    watch(0, 1'b0, 60, 1'b0);
    $display("test manual done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ba(IDX_REF_CFG), AM[i]);
      watch(0, 1'b0, 100, 1'b1);
      pri_run <= 1'b0;
      watch(0, 1'b1, 200, 1'b0);
      pri_run <= 1'b1;
      watch(0, i != 0, 200, i != 0);
      apb(1'b1, ba(IDX_REF_CFG), AM[i] & 8'hEF);
      watch(0, 1'b0, 100, 1'b0);
      apb(1'b1, ba(IDX_REF_CFG), AM[i]);
      watch(0, 1'b0, 100, 1'b1);
    end
    $display("test auto done");
    apb(1'b1, ba(IDX_CAL), 32'h0000_0001);
    watch(2, 1'b1, 20, 1'b0);
    watch(2, 1'b0, 20, 1'b1);
    $display("test cal done");
    end_of_test;
  end
endmodule : pllrs_top_bench
`default_nettype wire
